// *** core/ecpp_pkg.sv ***
// Purpose: shared constants and types for the parallel port register block
// Assumes: byte-wide host bus, offsets relative to the port base
// Notes: bit 10 of the address selects the upper bank
package ecpp_pkg;
    localparam logic [10:0] OFF_DATA = 11'h000;
    localparam logic [10:0] OFF_STATUS = 11'h001;
    localparam logic [10:0] OFF_CONTROL = 11'h002;
    localparam logic [10:0] OFF_FIFO = 11'h400;
    localparam logic [10:0] OFF_CFGB = 11'h401;
    localparam logic [10:0] OFF_EXTCTL = 11'h402;
    localparam logic [7:0] CAPABILITY_A_VALUE = 8'h10;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [5:0] CFGB_RESET = 6'h00;
    localparam int CTL_DIR_BIT = 5;
    localparam int CTL_ACKIE_BIT = 4;
    localparam int CTL_SELIN_BIT = 3;
    localparam int CTL_INIT_BIT = 2;
    localparam int CTL_AFD_BIT = 1;
    localparam int CTL_STB_BIT = 0;
    localparam int FIFO_DEPTH = 16;
    localparam int WRITE_THRESHOLD = 8;
    localparam int READ_THRESHOLD = 8;
    localparam int HS_PULSE_NS = 500;
    localparam int CLK_PERIOD_NS = 10;
    localparam int HS_PULSE_CYCLES = (HS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        MODE_STD = 3'b000,
        MODE_BIDIR = 3'b001,
        MODE_PPFIFO = 3'b010,
        MODE_ECP = 3'b011,
        MODE_EPP = 3'b100,
        MODE_RSVD = 3'b101,
        MODE_TEST = 3'b110,
        MODE_CONFIG = 3'b111
    } ecpp_mode_e;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_SETUP = 2'b01,
        HS_STROBE = 2'b10,
        HS_HOLD = 2'b11
    } ecpp_hs_e;

    // one FIFO entry: tag marks an address/RLE byte
    typedef struct packed {
        logic tag;
        logic [7:0] data;
    } ecpp_entry_s;

    // live peripheral status after synchronising
    typedef struct packed {
        logic busy;
        logic ackReply;
        logic paperEnd;
        logic online;
        logic error;
    } ecpp_status_s;
endpackage

// *** core/ecpp_port_regs.sv ***
// Purpose: host register set, shared FIFO and simple port drive of an ECP parallel port
// Assumes: single clock, strobes and pins pass a three-stage synchroniser
// Notes: handshakes are simplified single-pulse transfers
`timescale 1ns/1ns
`default_nettype none
module ecpp_port_regs
    import ecpp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int WR_THRESH = WRITE_THRESHOLD,
    parameter int RD_THRESH = READ_THRESHOLD
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [10:0] hostAddr,
    input wire logic chipSel_n,
    input wire logic io_write_strobe_n,
    input wire logic ioReadStrobe_n,
    input wire logic [7:0] hostWrData,
    output logic [7:0] hostRdData,
    input wire logic [7:0] port_data_lines_in,
    output logic [7:0] port_data_lines_out,
    output logic port_data_lines_oe,
    input wire logic errorIn_n,
    input wire logic online_in,
    input wire logic paper_end_in,
    input wire logic ackReplyIn_n,
    input wire logic busyIn,
    output logic strobeOut_n,
    output logic autofeedOut_n,
    output logic initOut_n,
    output logic selectInOut_n,
    output logic irqRequest,
    input wire logic irqLineIn,
    output logic service_flag
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);

    // three-stage synchronisers on every asynchronous input
    localparam int NSYNC = 16;
    // idle pin levels: strobes, ack and error high, everything else low, so no false edge
    localparam logic [NSYNC-1:0] SYNC_IDLE = 16'h0093;
    logic [NSYNC-1:0] syncIn;
    logic [NSYNC-1:0] sync1Reg, sync2Reg, sync3Reg;
    assign syncIn = {port_data_lines_in, errorIn_n, online_in, paper_end_in,
                     ackReplyIn_n, busyIn, irqLineIn, io_write_strobe_n, ioReadStrobe_n};
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1Reg <= SYNC_IDLE;
            sync2Reg <= SYNC_IDLE;
            sync3Reg <= SYNC_IDLE;
        end else begin
            sync1Reg <= syncIn;
            sync2Reg <= sync1Reg;
            sync3Reg <= sync2Reg;
        end
    end
    // a change counts once stages two and three agree
    logic [NSYNC-1:0] stableReg;
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : gStable
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    stableReg[g] <= SYNC_IDLE[g];
                end else if (sync2Reg[g] == sync3Reg[g]) begin
                    stableReg[g] <= sync3Reg[g];
                end
            end
        end
    endgenerate
    logic [7:0] pinData;
    ecpp_status_s pinStat;
    logic irqLevel, wrStb_n, rdStb_n;
    assign pinData = stableReg[15:8];
    assign pinStat = '{busy: stableReg[3], ackReply: stableReg[4], paperEnd: stableReg[5],
                       online: stableReg[6], error: stableReg[7]};
    assign irqLevel = stableReg[2];
    assign wrStb_n = stableReg[1];
    assign rdStb_n = stableReg[0];

    logic wrStbLastReg, rdStbLastReg, ackLastReg;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrStbLastReg <= 1'b1;
            rdStbLastReg <= 1'b1;
            ackLastReg <= 1'b1;
        end else begin
            wrStbLastReg <= wrStb_n;
            rdStbLastReg <= rdStb_n;
            ackLastReg <= pinStat.ackReply;
        end
    end
    logic wrEvt, rdEvt;
    // write on strobe rise, read on strobe fall so data is ready before the strobe ends
    assign wrEvt = !chipSel_n && wrStb_n && !wrStbLastReg;
    assign rdEvt = !chipSel_n && !rdStb_n && rdStbLastReg;

    function automatic logic hitOff(input logic [10:0] a, input logic [10:0] off);
        return a == off;
    endfunction

    // host registers
    logic [7:0] dataReg;
    logic [5:0] controlReg;
    ecpp_mode_e modeReg;
    logic [5:0] cfgbReg;
    logic svcReg;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataReg <= DATA_RESET;
        end else if (wrEvt && hitOff(hostAddr, OFF_DATA) && modeReg != MODE_ECP) begin
            dataReg <= hostWrData;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            controlReg <= CONTROL_RESET;
        end else if (wrEvt && hitOff(hostAddr, OFF_CONTROL)) begin
            controlReg <= hostWrData[5:0];
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            modeReg <= ecpp_mode_e'(MODE_RESET);
        end else if (wrEvt && hitOff(hostAddr, OFF_EXTCTL)) begin
            modeReg <= ecpp_mode_e'(hostWrData[7:5]);
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfgbReg <= CFGB_RESET;
        end else if (wrEvt && modeReg == MODE_CONFIG && hitOff(hostAddr, OFF_CFGB)) begin
            cfgbReg <= hostWrData[5:0];
        end
    end

    logic dirIn;
    // direction only honoured outside modes 000 and 010
    assign dirIn = controlReg[CTL_DIR_BIT] && modeReg != MODE_STD
                   && modeReg != MODE_PPFIFO;

    // shared sixteen-entry FIFO
    ecpp_entry_s fifoMem [DEPTH];
    logic [PW-1:0] wrPtrReg, rdPtrReg;
    logic [CW-1:0] countReg;
    logic [7:0] lastRdReg;
    logic fifoFull, fifoEmpty;
    assign fifoFull = countReg == CW'(DEPTH);
    assign fifoEmpty = countReg == '0;

    logic fifoView, hostPush, hostPop, portPush, portPop, doPush, doPop;
    ecpp_entry_s pushEntry;
    assign fifoView = modeReg == MODE_PPFIFO || modeReg == MODE_ECP || modeReg == MODE_TEST;
    // address/RLE writes only exist forward in mode 011
    logic afifoWr;
    assign afifoWr = wrEvt && hitOff(hostAddr, OFF_DATA) && modeReg == MODE_ECP && !dirIn;
    assign hostPush = (wrEvt && fifoView && hitOff(hostAddr, OFF_FIFO)
                       && !(modeReg == MODE_ECP && dirIn)) || afifoWr;
    assign hostPop = rdEvt && hitOff(hostAddr, OFF_FIFO)
                     && (modeReg == MODE_TEST || (modeReg == MODE_ECP && dirIn));
    // full writes are dropped, empty reads repeat the last byte
    assign doPush = (hostPush || portPush) && !fifoFull;
    assign doPop = (hostPop || portPop) && !fifoEmpty;
    assign pushEntry = portPush ? '{tag: !pinStat.busy, data: pinData}
                                : '{tag: afifoWr, data: hostWrData};

    always_ff @(posedge core_clk) begin
        if (doPush) begin
            fifoMem[wrPtrReg] <= pushEntry;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtrReg <= '0;
            rdPtrReg <= '0;
            countReg <= '0;
        end else if (modeReg == MODE_STD || modeReg == MODE_BIDIR) begin
            wrPtrReg <= '0;
            rdPtrReg <= '0;
            countReg <= '0;
        end else begin
            if (doPush) begin
                wrPtrReg <= wrPtrReg + PW'(1);
            end
            if (doPop) begin
                rdPtrReg <= rdPtrReg + PW'(1);
            end
            if (doPush && !doPop) begin
                countReg <= countReg + CW'(1);
            end else if (doPop && !doPush) begin
                countReg <= countReg - CW'(1);
            end
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lastRdReg <= 8'h00;
        end else if (hostPop && !fifoEmpty) begin
            lastRdReg <= fifoMem[rdPtrReg].data;
        end
    end

    // two-entry output buffer between FIFO and handshake engine
    ecpp_entry_s skidMem [2];
    logic skidWrReg, skidRdReg;
    logic [1:0] skidCntReg;
    logic skidReady, skidValid, hsTake;
    ecpp_hs_e hsStateReg;
    logic sendMode;
    // test mode never handshakes onto the port
    assign sendMode = (modeReg == MODE_PPFIFO || modeReg == MODE_ECP) && !dirIn;
    assign skidReady = skidCntReg != 2'h2;
    assign skidValid = skidCntReg != 2'h0;
    assign portPop = sendMode && skidReady && !fifoEmpty;
    assign hsTake = skidValid && hsStateReg == HS_IDLE && !pinStat.busy;
    always_ff @(posedge core_clk) begin
        if (portPop) begin
            skidMem[skidWrReg] <= fifoMem[rdPtrReg];
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            skidWrReg <= 1'b0;
            skidRdReg <= 1'b0;
            skidCntReg <= 2'h0;
        end else if (!sendMode && hsStateReg == HS_IDLE) begin
            skidWrReg <= 1'b0;
            skidRdReg <= 1'b0;
            skidCntReg <= 2'h0;
        end else begin
            if (portPop) begin
                skidWrReg <= !skidWrReg;
            end
            if (hsTake) begin
                skidRdReg <= !skidRdReg;
            end
            skidCntReg <= skidCntReg + {1'b0, portPop} - {1'b0, hsTake};
        end
    end

    // forward handshake: data setup, strobe pulse, hold
    logic [$clog2(HS_PULSE_CYCLES+1)-1:0] hsCntReg;
    ecpp_entry_s hsEntryReg;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hsStateReg <= HS_IDLE;
            hsCntReg <= '0;
            hsEntryReg <= '0;
        end else begin
            case (hsStateReg)
                HS_IDLE: begin
                    if (hsTake) begin
                        hsEntryReg <= skidMem[skidRdReg];
                        hsCntReg <= '0;
                        hsStateReg <= HS_SETUP;
                    end
                end
                HS_SETUP, HS_STROBE, HS_HOLD: begin
                    if (hsCntReg == ($bits(hsCntReg))'(HS_PULSE_CYCLES - 1)) begin
                        hsCntReg <= '0;
                        hsStateReg <= (hsStateReg == HS_HOLD) ? HS_IDLE
                                      : ecpp_hs_e'(hsStateReg + 2'h1);
                    end else begin
                        hsCntReg <= hsCntReg + ($bits(hsCntReg))'(1);
                    end
                end
                default: hsStateReg <= HS_IDLE;
            endcase
        end
    end

    // reverse fill: each ack fall with room in the FIFO captures a byte
    assign portPush = modeReg == MODE_ECP && dirIn
                      && !pinStat.ackReply && ackLastReg;

    // service flag thresholds, also measured in test mode
    logic svcCond;
    assign svcCond = fifoView && (dirIn ? (countReg >= CW'(RD_THRESH))
                                        : (CW'(DEPTH) - countReg >= CW'(WR_THRESH)));
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            svcReg <= 1'b1;
        end else if (svcCond) begin
            svcReg <= 1'b1;
        end else if (wrEvt && hitOff(hostAddr, OFF_EXTCTL)) begin
            svcReg <= hostWrData[2];
        end
    end

    // interrupt on ack rising edge when enabled
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqRequest <= 1'b0;
        end else begin
            irqRequest <= controlReg[CTL_ACKIE_BIT] && pinStat.ackReply && !ackLastReg;
        end
    end

    function automatic logic [7:0] readMux(input logic [10:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (hitOff(a, OFF_DATA)) begin
            v = pinData;
        end else if (hitOff(a, OFF_STATUS)) begin
            v = {!pinStat.busy, pinStat.ackReply, pinStat.paperEnd, pinStat.online,
                 pinStat.error, 3'b000};
        end else if (hitOff(a, OFF_CONTROL)) begin
            v = {2'b00, controlReg};
        end else if (hitOff(a, OFF_FIFO) && modeReg == MODE_CONFIG) begin
            v = CAPABILITY_A_VALUE;
        end else if (hitOff(a, OFF_CFGB) && modeReg == MODE_CONFIG) begin
            v = {1'b0, irqLevel, cfgbReg};
        end else if (hitOff(a, OFF_FIFO)) begin
            v = (fifoEmpty || !hostPop) ? lastRdReg : fifoMem[rdPtrReg].data;
        end else if (hitOff(a, OFF_EXTCTL)) begin
            v = {modeReg, 2'b00, svcReg, fifoFull, fifoEmpty};
        end
        return v;
    endfunction

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hostRdData <= 8'h00;
        end else if (rdEvt) begin
            hostRdData <= readMux(hostAddr);
        end
    end

    // port drive, all registered
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_data_lines_out <= 8'h00;
            port_data_lines_oe <= 1'b1;
            strobeOut_n <= 1'b1;
            autofeedOut_n <= 1'b1;
            initOut_n <= 1'b0;
            selectInOut_n <= 1'b1;
            service_flag <= 1'b1;
        end else begin
            port_data_lines_oe <= !dirIn;
            port_data_lines_out <= (hsStateReg != HS_IDLE) ? hsEntryReg.data : dataReg;
            strobeOut_n <= (hsStateReg == HS_STROBE) ? 1'b0 : !controlReg[CTL_STB_BIT];
            autofeedOut_n <= (modeReg == MODE_ECP && hsStateReg != HS_IDLE)
                             ? !hsEntryReg.tag : !controlReg[CTL_AFD_BIT];
            initOut_n <= controlReg[CTL_INIT_BIT];
            selectInOut_n <= !controlReg[CTL_SELIN_BIT];
            service_flag <= svcReg;
        end
    end
endmodule
`default_nettype wire

// *** tb/ecp_parallel_port_registers_bench.sv ***
// Purpose: self-checking bench of the parallel port register block
// Assumes: strobes held 10 cycles low, 8 high
// Notes: reverse fill is not exercised; the extended handshake only in the forward direction
`timescale 1ns/1ns
`default_nettype none
module ecp_parallel_port_registers_bench;
    import ecpp_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [10:0] hostAddr = 11'h000;
    logic chipSel_n = 1'b1;
    logic io_write_strobe_n = 1'b1;
    logic ioReadStrobe_n = 1'b1;
    logic [7:0] hostWrData = 8'h00;
    logic [7:0] hostRdData, port_data_lines_in, port_data_lines_out;
    logic port_data_lines_oe, busyIn, ackReplyIn_n, strobeOut_n, autofeedOut_n;
    logic initOut_n, selectInOut_n, irqRequest, service_flag;
    logic errorIn_n = 1'b1;
    logic online_in = 1'b0;
    logic paper_end_in = 1'b0;
    logic irqLineIn = 1'b0;
    logic stall = 1'b0;
    logic [7:0] irqSeen = 8'h00;
    int mismatches = 0;
    int n_checks = 0;
    logic [2:0] irqCode [7] = '{3'b110, 3'b101, 3'b100, 3'b011, 3'b010, 3'b001, 3'b111};
    always #5 core_clk = ~core_clk;
    ecpp_port_regs dut (.*);
    ecpp_periph u_per (.core_clk(core_clk), .strobeOut_n(strobeOut_n),
        .port_data_lines_out(port_data_lines_out), .port_data_lines_oe(port_data_lines_oe),
        .stall(stall), .busyIn(busyIn), .ackReplyIn_n(ackReplyIn_n),
        .lineLevel(port_data_lines_in));
    always @(posedge core_clk) begin
        if (irqRequest === 1'b1) irqSeen <= irqSeen + 8'h01;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [10:0] a, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge core_clk);
        #1;
        hostAddr = a;
        hostWrData = d;
        chipSel_n = 1'b0;
        io_write_strobe_n = !w;
        ioReadStrobe_n = w;
        repeat (10) @(posedge core_clk);
        q = hostRdData;
        #1;
        io_write_strobe_n = 1'b1;
        ioReadStrobe_n = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 chipSel_n = 1'b1;
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q & m, e);
    endtask
    task automatic t_reset();
        check({4'h0, strobeOut_n, autofeedOut_n, initOut_n, selectInOut_n}, 8'h0D);
        rdc(OFF_CONTROL, 8'hFF, 8'h00);
        rdc(OFF_EXTCTL, 8'hE0, 8'h00);
    endtask
    task automatic t_data();
        wr(OFF_DATA, 8'h5A);
        check(port_data_lines_out, 8'h5A);
        rdc(OFF_DATA, 8'hFF, 8'h5A);
        wr(OFF_EXTCTL, 8'h20);
        wr(OFF_CONTROL, 8'h20);
        check({7'h0, port_data_lines_oe}, 8'h00);
        rdc(OFF_DATA, 8'hFF, 8'hA5);
        wr(OFF_EXTCTL, 8'h00);
        check({7'h0, port_data_lines_oe}, 8'h01);
        wr(OFF_CONTROL, 8'hEF);
        check({4'h0, strobeOut_n, autofeedOut_n, initOut_n, selectInOut_n}, 8'h02);
        rdc(OFF_CONTROL, 8'hFF, 8'h2F);
        wr(OFF_CONTROL, 8'h00);
    endtask
    task automatic t_status();
        // let the printer finish acknowledging the last control strobe first
        repeat (30) @(posedge core_clk);
        #1 stall = 1'b1;
        errorIn_n = 1'b0;
        online_in = 1'b1;
        wr(OFF_CONTROL, 8'h01);
        wr(OFF_CONTROL, 8'h00);
        rdc(OFF_STATUS, 8'hFF, 8'h50);
        {errorIn_n, online_in, paper_end_in, stall} = 4'b1010;
        repeat (40) @(posedge core_clk);
        rdc(OFF_STATUS, 8'hFF, 8'hE8);
    endtask
    task automatic t_irq();
        irqSeen = 8'h00;
        wr(OFF_CONTROL, 8'h11);
        wr(OFF_CONTROL, 8'h10);
        repeat (40) @(posedge core_clk);
        check(irqSeen, 8'h01);
        wr(OFF_CONTROL, 8'h01);
        wr(OFF_CONTROL, 8'h00);
        repeat (40) @(posedge core_clk);
        check(irqSeen, 8'h01);
    endtask
    task automatic t_config();
        wr(OFF_EXTCTL, 8'hE0);
        rdc(OFF_FIFO, 8'hFF, 8'h10);
        irqLineIn = 1'b1;
        rdc(OFF_CFGB, 8'hFF, 8'h40);
        irqLineIn = 1'b0;
        for (int i = 0; i < 7; i++) begin
            wr(OFF_CFGB, {2'b11, irqCode[i], irqCode[(i + 3) % 7]});
            rdc(OFF_CFGB, 8'hFF, {2'b00, irqCode[i], irqCode[(i + 3) % 7]});
        end
        wr(OFF_EXTCTL, 8'h00);
    endtask
    task automatic t_test();
        wr(OFF_EXTCTL, 8'hC0);
        for (int i = 0; i < 3; i++) wr(OFF_FIFO, 8'h44 - 8'(i * 17));
        for (int i = 0; i < 3; i++) rdc(OFF_FIFO, 8'hFF, 8'h44 - 8'(i * 17));
        rdc(OFF_FIFO, 8'hFF, 8'h22);
        for (int i = 0; i <= FIFO_DEPTH; i++) wr(OFF_FIFO, 8'(i));
        rdc(OFF_EXTCTL, 8'hE3, 8'hC2);
        for (int i = 0; i < FIFO_DEPTH; i++) rdc(OFF_FIFO, 8'hFF, 8'(i));
        rdc(OFF_EXTCTL, 8'h03, 8'h01);
        wr(OFF_CONTROL, 8'h20);
        wr(OFF_EXTCTL, 8'hC0);
        for (int i = 0; i < READ_THRESHOLD; i++) begin
            check({7'h0, service_flag}, 8'h00);
            wr(OFF_FIFO, 8'(i));
        end
        check({7'h0, service_flag}, 8'h01);
        wr(OFF_EXTCTL, 8'h00);
        wr(OFF_CONTROL, 8'h00);
    endtask
    task automatic t_fifo();
        u_per.rxQ.delete();
        wr(OFF_EXTCTL, 8'h40);
        wr(OFF_FIFO, 8'hC3);
        wr(OFF_FIFO, 8'h3C);
        for (int i = 0; i < 1000 && u_per.rxQ.size() < 2; i++) @(posedge core_clk);
        check(8'(u_per.rxQ.size()), 8'h02);
        if (u_per.rxQ.size() == 2) check(u_per.rxQ[1], 8'h3C);
        repeat (60) @(posedge core_clk);
        wr(OFF_EXTCTL, 8'h00);
    endtask
    task automatic t_ecp();
        u_per.rxQ.delete();
        wr(OFF_EXTCTL, 8'h60);
        wr(OFF_DATA, 8'h81);
        for (int i = 0; i < 1000 && u_per.rxQ.size() < 1; i++) @(posedge core_clk);
        check({7'h0, autofeedOut_n}, 8'h00);
        check(8'(u_per.rxQ.size()), 8'h01);
        if (u_per.rxQ.size() == 1) check(u_per.rxQ[0], 8'h81);
        repeat (120) @(posedge core_clk);
        check(port_data_lines_out, 8'h5A);
        wr(OFF_EXTCTL, 8'h00);
    endtask
    task automatic complete_run();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        #1 reset_n = 1'b1;
        repeat (6) @(posedge core_clk);
        t_reset();
        t_data();
        t_status();
        t_irq();
        t_config();
        t_test();
        t_fifo();
        t_ecp();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire

// *** tb/ecpp_chk.sv ***
// Purpose: port-level checks of the parallel port register block
// Assumes: host strobes stay low and high at least eight cycles each
// Notes: mode is shadowed from host writes; settling is judged by a quiet counter
`timescale 1ns/1ns
`default_nettype none
module ecpp_chk
    import ecpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [10:0] hostAddr,
    input wire logic chipSel_n,
    input wire logic io_write_strobe_n,
    input wire logic ioReadStrobe_n,
    input wire logic [7:0] hostWrData,
    input wire logic [7:0] hostRdData,
    input wire logic [7:0] port_data_lines_in,
    input wire logic [7:0] port_data_lines_out,
    input wire logic port_data_lines_oe,
    input wire logic busyIn,
    input wire logic strobeOut_n,
    input wire logic autofeedOut_n,
    input wire logic initOut_n,
    input wire logic selectInOut_n,
    input wire logic irqRequest
);
    logic [2:0] modeReg;
    logic [3:0] ageReg;
    logic legacy;
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    assign legacy = modeReg == MODE_STD || modeReg == MODE_BIDIR;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            modeReg <= MODE_RESET;
        end else if ($rose(io_write_strobe_n) && !chipSel_n && hostAddr == OFF_EXTCTL) begin
            modeReg <= hostWrData[7:5];
        end
    end
    // any write restarts the count, so mode-based checks wait for the write to land
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ageReg <= 4'h0;
        end else if (!io_write_strobe_n) begin
            ageReg <= 4'h0;
        end else if (ageReg != 4'hF) begin
            ageReg <= ageReg + 4'h1;
        end
    end
    chk_status_low_zero: assert property (($fell(ioReadStrobe_n) && !chipSel_n && hostAddr == OFF_STATUS)
        ##1 (!ioReadStrobe_n)[*8] |-> hostRdData[2:0] == 3'h0) else $error("status low bits set");
    chk_status_busy_inv: assert property (($fell(ioReadStrobe_n) && !chipSel_n && hostAddr == OFF_STATUS)
        ##1 (!ioReadStrobe_n && $stable(busyIn))[*8] |-> hostRdData[7] == !busyIn)
        else $error("status busy bit not inverted");
    chk_data_read_live: assert property (($fell(ioReadStrobe_n) && !chipSel_n && hostAddr == OFF_DATA)
        ##1 (!ioReadStrobe_n && $stable(port_data_lines_in))[*8] |-> hostRdData == port_data_lines_in)
        else $error("data read differs from lines");
    chk_data_write_drv: assert property ($rose(io_write_strobe_n) && !chipSel_n
        && hostAddr == OFF_DATA && legacy |-> ##8 port_data_lines_out == $past(hostWrData, 8))
        else $error("data byte not driven");
    chk_ctrl_pins_follow: assert property ($rose(io_write_strobe_n) && !chipSel_n
        && hostAddr == OFF_CONTROL && legacy |-> ##8 {selectInOut_n, initOut_n, autofeedOut_n,
        strobeOut_n} == ($past(hostWrData[3:0], 8) ^ 4'hB)) else $error("control pins wrong");
    chk_fwd_mode_drives: assert property (ageReg == 4'hF && (modeReg == MODE_STD
        || modeReg == MODE_PPFIFO) |-> port_data_lines_oe) else $error("data lines released");
    chk_test_no_strobe: assert property (ageReg == 4'hF && modeReg == MODE_TEST
        |-> $stable(strobeOut_n)) else $error("strobe moved in test mode");
    chk_cap_a_value: assert property (($fell(ioReadStrobe_n) && !chipSel_n && hostAddr == OFF_FIFO
        && modeReg == MODE_CONFIG) ##1 (!ioReadStrobe_n)[*8] |-> hostRdData == CAPABILITY_A_VALUE)
        else $error("capability value wrong");
    chk_irq_one_pulse: assert property (irqRequest |=> !irqRequest) else $error("irq wider than one");
endmodule
bind ecpp_port_regs ecpp_chk u_chk (.*);
`default_nettype wire

// *** tb/ecpp_periph.sv ***
// Purpose: behavioural printer on the far side of the port
// Assumes: strobe low marks a valid byte on the data lines
// Notes: stall holds busy high to model a slow printer
`timescale 1ns/1ns
`default_nettype none
module ecpp_periph (
    input wire logic core_clk,
    input wire logic strobeOut_n,
    input wire logic [7:0] port_data_lines_out,
    input wire logic port_data_lines_oe,
    input wire logic stall,
    output logic busyIn,
    output logic ackReplyIn_n,
    output logic [7:0] lineLevel
);
    logic [7:0] rxQ[$];
    logic [7:0] lastOut = 8'h00;
    initial begin
        busyIn = 1'b0;
        ackReplyIn_n = 1'b1;
    end
    // released lines show the inverse of the last drive, so a stale copy cannot pass
    assign lineLevel = port_data_lines_oe ? port_data_lines_out : ~lastOut;
    always @(posedge core_clk) begin
        if (port_data_lines_oe === 1'b1) lastOut <= port_data_lines_out;
    end
    always begin
        @(negedge strobeOut_n);
        rxQ.push_back(port_data_lines_out);
        @(posedge core_clk);
        #1 busyIn = 1'b1;
        @(posedge strobeOut_n);
        while (stall) @(posedge core_clk);
        repeat (20) @(posedge core_clk);
        #1 ackReplyIn_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 busyIn = 1'b0;
        ackReplyIn_n = 1'b1;
    end
endmodule
`default_nettype wire
